// file: src/rsc_pkg.sv
package rsc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_PLL_CTRL = 8'h10;
  localparam logic [7:0] ADDR_PUMP_CFG = 8'h17;
  localparam logic [7:0] ADDR_REF_CFG  = 8'h1C;
  localparam logic [7:0] ADDR_MAN_SEL  = 8'h1D;
  localparam logic [7:0] ADDR_STATUS   = 8'h1F;

  // reset values: pll off, all reference buffers off
  localparam logic [7:0] RST_PLL_CTRL  = 8'h01;
  localparam logic [7:0] RST_PUMP_CFG  = 8'h00;
  localparam logic [7:0] RST_REF_CFG   = 8'h06;
  localparam logic [7:0] RST_MAN_SEL   = 8'h00;

  // pll power-down codes
  localparam logic [1:0] PD_NORMAL     = 2'h0;
  localparam logic [1:0] PD_OFF        = 2'h1;

  // charge pump modes
  localparam logic [2:0] CP_HIZ        = 3'h0;
  localparam logic [2:0] CP_UP         = 3'h1;
  localparam logic [2:0] CP_DOWN       = 3'h2;
  localparam logic [2:0] CP_NORMAL     = 3'h3;

  // switchover edge counts
  localparam logic [2:0] MISS_EDGES    = 3'h2;
  localparam logic [2:0] RETURN_EDGES  = 3'h4;
  localparam logic [2:0] RET_GAP_LIMIT = 3'h2;

  // bit positions of the synchronised input vector
  localparam int IN_PRI  = 0;
  localparam int IN_SEC  = 1;
  localparam int IN_RDIV = 2;
  localparam int IN_NDIV = 3;
  localparam int IN_SEL  = 4;
  localparam int IN_W    = 5;

  typedef enum logic [1:0] {ST_PRI, ST_MISS_WAIT, ST_SEC} rsc_state_t;

  typedef struct packed {
    logic       polarity_neg;
    logic [2:0] cp_mode;
    logic [1:0] rsv;
    logic [1:0] pd;
  } rsc_pll_ctrl_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic [2:0] cp_current;
    logic [1:0] abp;
  } rsc_pump_cfg_t;

  typedef struct packed {
    logic deglitch;
    logic rsv;
    logic pin_sel;
    logic auto_en;
    logic stay_sec;
    logic sec_pd;
    logic pri_pd;
    logic diff_en;
  } rsc_ref_cfg_t;

endpackage

// file: src/rsc_switchover.sv
// Summary of operation
// RULE_01 - two secondary falls, no primary edge: missing
// RULE_02 - then secondary used from next secondary rise
// RULE_03 - return after four clean primary rises
// RULE_04 - stay bit set: never return automatically
// RULE_05 - software returns via manual primary, then auto
// RULE_06 - manual choice from register or select pin
// RULE_07 - deglitch blocks stray edges at switchover
// RULE_08 - manual switch needs clock or deglitch off
// RULE_09 - switching only in dual single-ended mode
// RULE_10 - all reference buffers off after reset
// RULE_11 - differential buffer off unless selected, pll on
// RULE_12 - single-ended buffer off: pll off or own bit
// RULE_13 - differential type forces single-ended buffers off
// RULE_14 - type and auto mode share one register
// RULE_15 - pump modes: hi-z, normal, up, down
// RULE_16 - pump current has eight steps
// RULE_17 - two-bit antibacklash width field
// RULE_18 - detector compares dividers, drives up/down
// RULE_19 - polarity bit clear positive, set negative
// RULE_20 - power-down code off or zero for normal
// RULE_21 - edge counters clear when condition broken
// RULE_22 - auto/manual bit and stay/return bit
`timescale 1ns/1ps
`default_nettype none

module rsc_switchover (
  input  wire logic       MCLK,
  input  wire logic       RST,
  input  wire logic       CE,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       PRI_REF,
  input  wire logic       SEC_REF,
  input  wire logic       REF_SEL_PIN,
  input  wire logic       R_DIV_OUT,
  input  wire logic       N_DIV_OUT,
  output logic            REF_TO_PLL,
  output logic            USE_SECONDARY,
  output logic            PLL_PD,
  output logic            DIFF_BUF_PD,
  output logic            PRI_BUF_PD,
  output logic            SEC_BUF_PD,
  output logic            PUMP_UP,
  output logic            PUMP_DN,
  output logic            PUMP_HIZ,
  output logic      [2:0] PUMP_CURRENT,
  output logic      [1:0] ABP_WIDTH
);

  // saturating three-bit increment
  function automatic logic [2:0] sat_inc(input logic [2:0] v);
    return (v == 3'h7) ? v : v + 3'h1;
  endfunction

  rsc_pkg::rsc_pll_ctrl_t   pll_ctrl;
  rsc_pkg::rsc_pump_cfg_t   pump_cfg;
  rsc_pkg::rsc_ref_cfg_t    ref_cfg;
  logic [7:0]               man_sel;
  logic [7:0]               rd_mux;
  logic [7:0]               status;
  logic [rsc_pkg::IN_W-1:0] s1;
  logic [rsc_pkg::IN_W-1:0] s2;
  logic [rsc_pkg::IN_W-1:0] s3;
  logic [rsc_pkg::IN_W-1:0] filt;
  logic [rsc_pkg::IN_W-1:0] filt_d;
  logic [rsc_pkg::IN_W-1:0] next_filt;
  logic [rsc_pkg::IN_W-1:0] rise;
  logic [rsc_pkg::IN_W-1:0] fall;
  rsc_pkg::rsc_state_t      state;
  rsc_pkg::rsc_state_t      next_state;
  logic [2:0]               miss_cnt;
  logic [2:0]               next_miss_cnt;
  logic [2:0]               ret_cnt;
  logic [2:0]               next_ret_cnt;
  logic [2:0]               ret_gap;
  logic [2:0]               next_ret_gap;
  logic                     blank;
  logic                     next_blank;
  logic                     up_q;
  logic                     dn_q;
  logic [1:0]               abp_cnt;
  logic                     next_up;
  logic                     next_dn;
  logic [1:0]               next_abp_cnt;
  logic                     pfd_clr;
  logic                     pfd_up;
  logic                     pfd_dn;
  logic                     next_pump_up;
  logic                     next_pump_dn;
  logic                     next_pump_hiz;

  // register file writes
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pll_ctrl <= rsc_pkg::RST_PLL_CTRL; // RULE_10
      pump_cfg <= rsc_pkg::RST_PUMP_CFG;
      ref_cfg  <= rsc_pkg::RST_REF_CFG; // RULE_10
      man_sel  <= rsc_pkg::RST_MAN_SEL;
    end else if (CE && WR) begin
      if (ADDR == rsc_pkg::ADDR_PLL_CTRL) begin
        pll_ctrl <= WDATA;
      end else if (ADDR == rsc_pkg::ADDR_PUMP_CFG) begin
        pump_cfg <= WDATA;
      end else if (ADDR == rsc_pkg::ADDR_REF_CFG) begin
        ref_cfg <= WDATA; // RULE_14
      end else if (ADDR == rsc_pkg::ADDR_MAN_SEL) begin
        man_sel <= {7'h00, WDATA[0]};
      end
    end
  end

  // read decode, unmapped reads give zero
  always_comb begin
    if (ADDR == rsc_pkg::ADDR_PLL_CTRL) begin
      rd_mux = pll_ctrl;
    end else if (ADDR == rsc_pkg::ADDR_PUMP_CFG) begin
      rd_mux = pump_cfg;
    end else if (ADDR == rsc_pkg::ADDR_REF_CFG) begin
      rd_mux = ref_cfg;
    end else if (ADDR == rsc_pkg::ADDR_MAN_SEL) begin
      rd_mux = man_sel;
    end else if (ADDR == rsc_pkg::ADDR_STATUS) begin
      rd_mux = status;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge MCLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (CE) begin
      RDATA <= RD ? rd_mux : 8'h00;
    end
  end

  // three-stage synchronisers, a change counts when stages two and three agree
  assign next_filt = (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
  assign rise      = filt & ~filt_d;
  assign fall      = ~filt & filt_d;
  always_ff @(posedge MCLK) begin
    if (RST) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      filt   <= '0;
      filt_d <= '0;
    end else if (CE) begin
      s1     <= {REF_SEL_PIN, N_DIV_OUT, R_DIV_OUT, SEC_REF, PRI_REF};
      s2     <= s1;
      s3     <= s2;
      filt   <= next_filt;
      filt_d <= filt;
    end
  end

  // buffer power control
  wire pll_off  = (pll_ctrl.pd != rsc_pkg::PD_NORMAL);                          // RULE_20
  wire diff_pd  = pll_off | ~ref_cfg.diff_en;                                    // RULE_11
  wire pri_pd   = pll_off | ref_cfg.pri_pd | ref_cfg.diff_en;                    // RULE_12 RULE_13
  wire sec_pd   = pll_off | ref_cfg.sec_pd | ref_cfg.diff_en;                    // RULE_12 RULE_13
  wire pri_live = ref_cfg.diff_en ? ~diff_pd : ~pri_pd;
  wire sec_live = ~sec_pd;
  // reference activity seen through live buffers only
  wire pri_lvl  = filt[rsc_pkg::IN_PRI] & pri_live;
  wire sec_lvl  = filt[rsc_pkg::IN_SEC] & sec_live;
  wire pri_rise = rise[rsc_pkg::IN_PRI] & pri_live;
  wire pri_edge = (rise[rsc_pkg::IN_PRI] | fall[rsc_pkg::IN_PRI]) & pri_live;
  wire sec_rise = rise[rsc_pkg::IN_SEC] & sec_live;
  wire sec_fall = fall[rsc_pkg::IN_SEC] & sec_live;
  // mode decode
  wire dual_se  = ~ref_cfg.diff_en;                                              // RULE_09
  wire auto_on  = ref_cfg.auto_en & dual_se;                                     // RULE_22
  wire man_sec  = ref_cfg.pin_sel ? filt[rsc_pkg::IN_SEL] : man_sel[0];          // RULE_06
  // missing and return counters
  assign next_miss_cnt = pri_edge ? 3'h0 : (sec_fall ? sat_inc(miss_cnt) : miss_cnt); // RULE_21
  assign next_ret_gap  = pri_rise ? 3'h0 : (sec_fall ? sat_inc(ret_gap) : ret_gap);   // RULE_21
  assign next_ret_cnt  = pri_rise ? ((ret_gap >= rsc_pkg::RET_GAP_LIMIT) ? 3'h1 : sat_inc(ret_cnt))
                       : ((next_ret_gap >= rsc_pkg::RET_GAP_LIMIT) ? 3'h0 : ret_cnt);  // RULE_21
  wire pri_missing = (next_miss_cnt >= rsc_pkg::MISS_EDGES);                     // RULE_01
  wire pri_back    = (next_ret_cnt >= rsc_pkg::RETURN_EDGES);                    // RULE_03
  // switchover state machine
  always_comb begin
    next_state = state;
    if (!dual_se) begin
      next_state = rsc_pkg::ST_PRI;                                              // RULE_09
    end else if (!auto_on) begin
      next_state = man_sec ? rsc_pkg::ST_SEC : rsc_pkg::ST_PRI;                  // RULE_05
    end else begin
      case (state)
        rsc_pkg::ST_PRI: begin
          if (pri_missing) next_state = rsc_pkg::ST_MISS_WAIT;                   // RULE_01
        end
        rsc_pkg::ST_MISS_WAIT: begin
          if (sec_rise) next_state = rsc_pkg::ST_SEC;                            // RULE_02
        end
        rsc_pkg::ST_SEC: begin
          if (!ref_cfg.stay_sec && pri_back) next_state = rsc_pkg::ST_PRI;       // RULE_03 RULE_04
        end
        default: begin
          next_state = rsc_pkg::ST_PRI;
        end
      endcase
    end
  end

  // deglitch: on a switch, hold the output low until the new source rises
  wire sel_sec    = (state == rsc_pkg::ST_SEC);
  wire switching  = ((next_state == rsc_pkg::ST_SEC) != sel_sec);
  wire new_rise   = sel_sec ? sec_rise : pri_rise;
  assign next_blank = (switching && ref_cfg.deglitch) ? 1'b1 : (new_rise ? 1'b0 : blank); // RULE_07

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state    <= rsc_pkg::ST_PRI;
      miss_cnt <= 3'h0;
      ret_cnt  <= 3'h0;
      ret_gap  <= 3'h0;
      blank    <= 1'b0;
    end else if (CE) begin
      state    <= next_state;
      miss_cnt <= next_miss_cnt;
      ret_cnt  <= next_ret_cnt;
      ret_gap  <= next_ret_gap;
      blank    <= next_blank;
    end
  end

  // phase detector with antibacklash overlap
  wire ref_rise = rise[rsc_pkg::IN_RDIV];
  wire fb_rise  = rise[rsc_pkg::IN_NDIV];
  assign pfd_clr      = up_q & dn_q & (abp_cnt == pump_cfg.abp);                 // RULE_17
  assign next_up      = ref_rise | (up_q & ~pfd_clr);                            // RULE_18
  assign next_dn      = fb_rise | (dn_q & ~pfd_clr);                             // RULE_18
  assign next_abp_cnt = (up_q & dn_q & ~pfd_clr) ? abp_cnt + 2'h1 : 2'h0;
  assign pfd_up       = pll_ctrl.polarity_neg ? dn_q : up_q;                     // RULE_19
  assign pfd_dn       = pll_ctrl.polarity_neg ? up_q : dn_q;                     // RULE_19

  // charge pump mode selection
  always_comb begin
    next_pump_up  = 1'b0;
    next_pump_dn  = 1'b0;
    next_pump_hiz = 1'b0;
    case (pll_ctrl.cp_mode)
      rsc_pkg::CP_NORMAL: begin
        next_pump_up = pfd_up & ~pll_off;
        next_pump_dn = pfd_dn & ~pll_off;
      end
      rsc_pkg::CP_UP: begin
        next_pump_up = 1'b1;
      end
      rsc_pkg::CP_DOWN: begin
        next_pump_dn = 1'b1;
      end
      default: begin
        next_pump_hiz = 1'b1;                                                    // RULE_15
      end
    endcase
  end
  // detector and antibacklash flops
  always_ff @(posedge MCLK) begin
    if (RST) begin
      up_q    <= 1'b0;
      dn_q    <= 1'b0;
      abp_cnt <= 2'h0;
    end else if (CE) begin
      up_q    <= next_up;
      dn_q    <= next_dn;
      abp_cnt <= next_abp_cnt;
    end
  end
  // status word for software
  assign status = {4'h0, auto_on, blank, (state != rsc_pkg::ST_PRI), sel_sec};

  // registered outputs
  always_ff @(posedge MCLK) begin
    if (RST) begin
      REF_TO_PLL    <= 1'b0;
      USE_SECONDARY <= 1'b0;
      PLL_PD        <= 1'b1;
      DIFF_BUF_PD   <= 1'b1;
      PRI_BUF_PD    <= 1'b1;
      SEC_BUF_PD    <= 1'b1;
      PUMP_UP       <= 1'b0;
      PUMP_DN       <= 1'b0;
      PUMP_HIZ      <= 1'b1;
      PUMP_CURRENT  <= 3'h0;
      ABP_WIDTH     <= 2'h0;
    end else if (CE) begin
      REF_TO_PLL    <= (sel_sec ? sec_lvl : pri_lvl) & ~blank;                   // RULE_07
      USE_SECONDARY <= sel_sec;
      PLL_PD        <= pll_off;
      DIFF_BUF_PD   <= diff_pd;
      PRI_BUF_PD    <= pri_pd;
      SEC_BUF_PD    <= sec_pd;
      PUMP_UP       <= next_pump_up;
      PUMP_DN       <= next_pump_dn;
      PUMP_HIZ      <= next_pump_hiz;
      PUMP_CURRENT  <= pump_cfg.cp_current;                                      // RULE_16
      ABP_WIDTH     <= pump_cfg.abp;
    end
  end

  // checks
  sequence s_declare;
    state == rsc_pkg::ST_PRI && auto_on && sec_fall && !pri_edge && miss_cnt == 3'h1;
  endsequence
  sequence s_waiting;
    state == rsc_pkg::ST_MISS_WAIT && auto_on && sec_rise;
  endsequence
  property p_missing;
    @(posedge MCLK) disable iff (RST || !CE) s_declare |=> state == rsc_pkg::ST_MISS_WAIT;
  endproperty
  a_missing: assert property (p_missing) else $error("primary not declared missing"); // RULE_01
  property p_to_secondary;
    @(posedge MCLK) disable iff (RST || !CE) s_waiting |=> sel_sec ##1 USE_SECONDARY;
  endproperty
  a_to_secondary: assert property (p_to_secondary) else $error("secondary not taken"); // RULE_02
  property p_return;
    @(posedge MCLK) disable iff (RST || !CE)
      state == rsc_pkg::ST_SEC && auto_on && !ref_cfg.stay_sec && pri_rise
      && ret_gap < rsc_pkg::RET_GAP_LIMIT && ret_cnt == 3'h3 |=> state == rsc_pkg::ST_PRI;
  endproperty
  a_return: assert property (p_return) else $error("no return to primary"); // RULE_03
  property p_stay;
    @(posedge MCLK) disable iff (RST || !CE)
      state == rsc_pkg::ST_SEC && auto_on && ref_cfg.stay_sec |=> state == rsc_pkg::ST_SEC;
  endproperty
  a_stay: assert property (p_stay) else $error("left secondary in stay mode"); // RULE_04
  property p_no_switch_diff;
    @(posedge MCLK) disable iff (RST || !CE) ref_cfg.diff_en |=> !sel_sec;
  endproperty
  a_no_switch_diff: assert property (p_no_switch_diff) else $error("switch in differential mode"); // RULE_09
  property p_deglitch;
    @(posedge MCLK) disable iff (RST || !CE) s_waiting ##0 ref_cfg.deglitch |=> blank ##1 !REF_TO_PLL;
  endproperty
  a_deglitch: assert property (p_deglitch) else $error("edge passed while blanked"); // RULE_07
  property p_diff_pd;
    @(posedge MCLK) disable iff (RST || !CE) (pll_off || !ref_cfg.diff_en) |=> DIFF_BUF_PD;
  endproperty
  a_diff_pd: assert property (p_diff_pd) else $error("differential buffer left on"); // RULE_11
  property p_se_pd;
    @(posedge MCLK) disable iff (RST || !CE) ref_cfg.diff_en |=> PRI_BUF_PD && SEC_BUF_PD;
  endproperty
  a_se_pd: assert property (p_se_pd) else $error("single-ended buffer on in differential"); // RULE_13
  property p_counter_clear;
    @(posedge MCLK) disable iff (RST || !CE) pri_edge |=> miss_cnt == 3'h0;
  endproperty
  a_counter_clear: assert property (p_counter_clear) else $error("missing count not cleared"); // RULE_21
  property p_hiz;
    @(posedge MCLK) disable iff (RST || !CE)
      pll_ctrl.cp_mode == rsc_pkg::CP_HIZ |=> PUMP_HIZ && !PUMP_UP && !PUMP_DN;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pump not high impedance"); // RULE_15
  property p_pd_off;
    @(posedge MCLK) disable iff (RST || !CE)
      pll_ctrl.pd == rsc_pkg::PD_OFF |=> PLL_PD && PRI_BUF_PD && SEC_BUF_PD;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("pll off but buffers on"); // RULE_20 RULE_12
endmodule
`default_nettype wire

// file: verif/rsc_ref_model.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_ref_model #(
  parameter int HALF = 12
) (
  input  wire logic mclk,
  input  wire logic pri_run,
  input  wire logic sec_run,
  output logic      pri_ref,
  output logic      sec_ref
);
  int   pri_cnt = 0;
  int   sec_cnt = 0;
  logic pri_q   = 1'b0;
  logic sec_q   = 1'b0;

  // dc-coupled sources: a dead source holds low, it never floats
  assign pri_ref = pri_q;
  assign sec_ref = sec_q;

  // primary toggles every HALF clocks while alive
  always @(posedge mclk) begin
    if (!pri_run) begin
      pri_cnt <= 0;
      pri_q   <= 1'b0;
    end else if (pri_cnt == HALF - 1) begin
      pri_cnt <= 0;
      pri_q   <= ~pri_q;
    end else begin
      pri_cnt <= pri_cnt + 1;
    end
  end

  // secondary runs whenever enabled, so a manual target always has a clock
  always @(posedge mclk) begin
    if (!sec_run) begin
      sec_cnt <= 0;
      sec_q   <= 1'b0;
    end else if (sec_cnt == HALF - 1) begin
      sec_cnt <= 0;
      sec_q   <= ~sec_q;
    end else begin
      sec_cnt <= sec_cnt + 1;
    end
  end
endmodule

`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic       MCLK        = 1'b0;
  logic       RST         = 1'b1;
  logic [7:0] ADDR        = 8'h00;
  logic [7:0] WDATA       = 8'h00;
  logic       WR          = 1'b0;
  logic       RD          = 1'b0;
  logic       REF_SEL_PIN = 1'b0;
  logic       R_DIV_OUT   = 1'b0;
  logic       N_DIV_OUT   = 1'b0;
  logic       pri_run     = 1'b1;
  wire logic  PRI_REF;
  wire logic  SEC_REF;
  wire logic [7:0] RDATA;
  wire logic  REF_TO_PLL, USE_SECONDARY, PLL_PD, DIFF_BUF_PD, PRI_BUF_PD, SEC_BUF_PD;
  wire logic  PUMP_UP, PUMP_DN, PUMP_HIZ;
  wire logic [2:0] PUMP_CURRENT;
  wire logic [1:0] ABP_WIDTH;
  int         num_errors  = 0;
  int         checks      = 0;
  int         pri_rises   = 0;
  int         sec_falls   = 0;
  int         rise_mark   = 0;
  int         fall_mark   = 0;

  rsc_switchover uut (.MCLK(MCLK), .RST(RST), .CE(1'b1), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PRI_REF(PRI_REF), .SEC_REF(SEC_REF), .REF_SEL_PIN(REF_SEL_PIN), .R_DIV_OUT(R_DIV_OUT),
    .N_DIV_OUT(N_DIV_OUT), .REF_TO_PLL(REF_TO_PLL), .USE_SECONDARY(USE_SECONDARY), .PLL_PD(PLL_PD),
    .DIFF_BUF_PD(DIFF_BUF_PD), .PRI_BUF_PD(PRI_BUF_PD), .SEC_BUF_PD(SEC_BUF_PD), .PUMP_UP(PUMP_UP),
    .PUMP_DN(PUMP_DN), .PUMP_HIZ(PUMP_HIZ), .PUMP_CURRENT(PUMP_CURRENT), .ABP_WIDTH(ABP_WIDTH));

  rsc_ref_model src (.mclk(MCLK), .pri_run(pri_run), .sec_run(1'b1), .pri_ref(PRI_REF), .sec_ref(SEC_REF));

  // 100 mhz clock
  initial begin
    forever #5 MCLK = ~MCLK;
  end

  // edge counters for the switchover scenarios
  always @(posedge PRI_REF) pri_rises++;
  always @(negedge SEC_REF) sec_falls++;

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle write, then let the outputs follow
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
  endtask

  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge MCLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    chk("rdata", RDATA, exp);
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return USE_SECONDARY;
      1: return PUMP_UP;
      default: return PUMP_DN;
    endcase
  endfunction

  // bounded wait for a design output to reach a level
  task automatic wait_for(input int sel, input logic v);
    int n;
    n = 0;
    while (pick(sel) !== v && n < 3000) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    if (n == 3000) begin
      num_errors++;
      $display("wrong value wait%0d expected %b seen %b", sel, v, pick(sel));
      stop_test();
    end
  endtask

  // stop the primary well clear of a secondary fall
  task automatic kill_pri();
    int n;
    int m;
    n = 0;
    m = sec_falls;
    while (sec_falls == m && n < 100) begin
      @(posedge MCLK);
      n++;
    end
    if (n == 100) begin
      num_errors++;
      $display("wrong value sec_fall expected 1 seen 0");
      stop_test();
    end
    @(posedge MCLK);
    pri_run <= 1'b0;
    #1;
    fall_mark = sec_falls;
  endtask

  task automatic start_pri();
    @(posedge MCLK);
    pri_run <= 1'b1;
    #1;
    rise_mark = pri_rises;
  endtask

  initial begin
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    #1;
    // power-up state
    chk("pll_pd", PLL_PD, 8'h01);
    chk("buf_pd", {DIFF_BUF_PD, PRI_BUF_PD, SEC_BUF_PD}, 8'h07);
    rd(rsc_pkg::ADDR_PLL_CTRL, rsc_pkg::RST_PLL_CTRL);
    rd(rsc_pkg::ADDR_REF_CFG, rsc_pkg::RST_REF_CFG);
    rd(rsc_pkg::ADDR_PUMP_CFG, rsc_pkg::RST_PUMP_CFG);
    rd(rsc_pkg::ADDR_MAN_SEL, rsc_pkg::RST_MAN_SEL);
    rd(8'h3A, 8'h00);
    // buffer power gating
    wr(rsc_pkg::ADDR_PLL_CTRL, 8'h30);
    chk("pll_pd", PLL_PD, 8'h00);
    chk("buf_pd", {DIFF_BUF_PD, PRI_BUF_PD, SEC_BUF_PD}, 8'h07);
    wr(rsc_pkg::ADDR_REF_CFG, 8'h01);
    chk("buf_pd", {DIFF_BUF_PD, PRI_BUF_PD, SEC_BUF_PD}, 8'h03);
    wr(rsc_pkg::ADDR_REF_CFG, 8'h04);
    chk("buf_pd", {DIFF_BUF_PD, PRI_BUF_PD, SEC_BUF_PD}, 8'h05);
    wr(rsc_pkg::ADDR_PLL_CTRL, 8'h31);
    chk("buf_pd", {DIFF_BUF_PD, PRI_BUF_PD, SEC_BUF_PD}, 8'h07);
    // pump modes, pll on
    for (int m = 0; m < 4; m++) begin
      wr(rsc_pkg::ADDR_PLL_CTRL, {1'b0, 3'(m), 4'h0});
      chk("pump_up", PUMP_UP, 8'(3'(m) == rsc_pkg::CP_UP));
      chk("pump_dn", PUMP_DN, 8'(3'(m) == rsc_pkg::CP_DOWN));
      if (3'(m) != rsc_pkg::CP_NORMAL) chk("pump_hiz", PUMP_HIZ, 8'(3'(m) == rsc_pkg::CP_HIZ));
    end
    // current steps and antibacklash field
    for (int i = 0; i < 8; i++) begin
      wr(rsc_pkg::ADDR_PUMP_CFG, {3'h0, 3'(i), 2'(i)});
      chk("current", PUMP_CURRENT, 8'(i));
      chk("abp", ABP_WIDTH, 8'(i % 4));
      rd(rsc_pkg::ADDR_PUMP_CFG, {3'h0, 3'(i), 2'(i)});
    end
    // detector, both polarities
    for (int p = 0; p < 2; p++) begin
      wr(rsc_pkg::ADDR_PLL_CTRL, {1'(p), 7'h30});
      @(posedge MCLK);
      R_DIV_OUT <= 1'b1;
      wait_for(1 + p, 1'b1);
      chk("other_dir", pick(2 - p), 8'h00);
      @(posedge MCLK);
      N_DIV_OUT <= 1'b1;
      wait_for(1 + p, 1'b0);
      @(posedge MCLK);
      R_DIV_OUT <= 1'b0;
      N_DIV_OUT <= 1'b0;
    end
    // manual selection from register, then from the pin
    wr(rsc_pkg::ADDR_PLL_CTRL, 8'h30);
    wr(rsc_pkg::ADDR_REF_CFG, 8'h00);
    wr(rsc_pkg::ADDR_MAN_SEL, 8'h01);
    wait_for(0, 1'b1);
    wr(rsc_pkg::ADDR_MAN_SEL, 8'h00);
    wait_for(0, 1'b0);
    wr(rsc_pkg::ADDR_REF_CFG, 8'h20);
    @(posedge MCLK);
    REF_SEL_PIN <= 1'b1;
    wait_for(0, 1'b1);
    @(posedge MCLK);
    REF_SEL_PIN <= 1'b0;
    wait_for(0, 1'b0);
    // automatic, prefer primary
    wr(rsc_pkg::ADDR_REF_CFG, 8'h10);
    rd(rsc_pkg::ADDR_REF_CFG, 8'h10);
    kill_pri();
    wait_for(0, 1'b1);
    chk("falls", 8'(sec_falls - fall_mark), 8'h02);
    chk("ref_out", REF_TO_PLL, 8'h01);
    start_pri();
    repeat (40) @(posedge MCLK);
    pri_run <= 1'b0;
    repeat (80) @(posedge MCLK);
    #1;
    chk("use_sec", USE_SECONDARY, 8'h01);
    start_pri();
    wait_for(0, 1'b0);
    chk("rises", 8'(pri_rises - rise_mark), 8'h04);
    // deglitch holds back the switching edge
    wr(rsc_pkg::ADDR_REF_CFG, 8'h90);
    kill_pri();
    wait_for(0, 1'b1);
    chk("ref_out", REF_TO_PLL, 8'h00);
    start_pri();
    wait_for(0, 1'b0);
    // stay on secondary, then software return
    wr(rsc_pkg::ADDR_REF_CFG, 8'h18);
    kill_pri();
    wait_for(0, 1'b1);
    start_pri();
    repeat (200) @(posedge MCLK);
    #1;
    chk("use_sec", USE_SECONDARY, 8'h01);
    wr(rsc_pkg::ADDR_REF_CFG, 8'h08);
    wait_for(0, 1'b0);
    wr(rsc_pkg::ADDR_REF_CFG, 8'h18);
    repeat (50) @(posedge MCLK);
    #1;
    chk("use_sec", USE_SECONDARY, 8'h00);
    // differential mode never switches
    wr(rsc_pkg::ADDR_REF_CFG, 8'h11);
    kill_pri();
    repeat (150) @(posedge MCLK);
    #1;
    chk("use_sec", USE_SECONDARY, 8'h00);
    stop_test();
  end
endmodule

`default_nettype wire
